// ==== common/eirf_pkg.sv ====
// Constants for the external interrupt routing and system flag block
package eirf_pkg;

  // Register addresses and pages
  localparam logic [7:0] ADDR_SFLAG_EN   = 8'h8e;
  localparam logic [7:0] ADDR_PWR_FLAGS  = 8'h97;
  localparam logic [7:0] ADDR_AUX_FLAGS  = 8'ha3;
  localparam logic [7:0] ADDR_XCFG       = 8'hc1;
  localparam logic [3:0] PAGE_XCFG_LO    = 4'h0;
  localparam logic [3:0] PAGE_XCFG_HI    = 4'h1;
  localparam logic [3:0] PAGE_AUX        = 4'h0;

  // Reset values
  localparam logic [7:0] RST_SFLAG_EN    = 8'h00;
  localparam logic [7:0] RST_PWR_FLAGS   = 8'h00;
  localparam logic [7:0] RST_AUX_FLAGS   = 8'h00;
  localparam logic [7:0] RST_XCFG        = 8'h00;
  localparam logic [7:0] RST_RDATA       = 8'h00;

  // Implemented bits; reserved bits read as zero
  localparam logic [7:0] MASK_SFLAG_EN   = 8'h97;
  localparam logic [7:0] MASK_PWR_FLAGS  = 8'hd7;
  localparam logic [7:0] MASK_AUX_FLAGS  = 8'hcf;
  localparam logic [7:0] MASK_AUX_OPTS   = 8'h0f;
  localparam logic [7:0] MASK_XCFG       = 8'hf7;
  // Reset indicators keep an event that arrives during reset
  localparam logic [7:0] MASK_RST_KEEP   = 8'hc0;

  // Enable register fields
  localparam int BIT_BUS_DET_IE   = 7;
  localparam int BIT_RTC_IE       = 4;
  localparam int BIT_BO1_IE       = 2;
  localparam int BIT_BO0_IE       = 1;
  localparam int BIT_WDOG_IE      = 0;

  // Power event flag fields
  localparam int BIT_SOFT_RST     = 7;
  localparam int BIT_PIN_RST      = 6;
  localparam int BIT_RTC_OVF      = 4;
  localparam int BIT_BO1          = 2;
  localparam int BIT_BO0          = 1;
  localparam int BIT_WDOG_OVF     = 0;

  // Auxiliary register fields
  localparam int BIT_BUS_START    = 7;
  localparam int BIT_BUS_STOP     = 6;
  localparam int BIT_T1_FULL      = 3;
  localparam int BIT_T0_FULL      = 2;
  localparam int BIT_T1_CLKOUT    = 1;
  localparam int BIT_T0_CLKOUT    = 0;

  // Config fields: low register holds filter low bits at bit n for irq n
  localparam int BIT_IRQ1_SEL_LO  = 6;
  localparam int BIT_IRQ0_SEL_LO  = 4;
  localparam int BIT_IRQ1_SEL_HI  = 7;
  localparam int BIT_IRQ0_SEL_HI  = 6;
  localparam int BIT_IRQ2_SEL     = 4;

  // Filter modes
  localparam logic [1:0] FLT_OFF     = 2'h0;
  localparam logic [1:0] FLT_SYSTEM_CLOCK  = 2'h1;
  localparam logic [1:0] FLT_DIV6    = 2'h2;
  localparam logic [1:0] FLT_SERIAL0 = 2'h3;

  // Timing counts
  localparam int         SAMPLE_DIV   = 6;
  localparam logic [2:0] DIV6_MAX     = 3'(SAMPLE_DIV - 1);
  localparam int         TIMER_PRESC  = 12;
  localparam logic [3:0] PRESC_MAX    = 4'(TIMER_PRESC - 1);

  // Pin vector: port1 at 0, port2 at 8, port3 at 16, port4 at 24, port6 at 32
  localparam int         PIN_W = 40;
  localparam logic [5:0] P1_0 = 6'h00;
  localparam logic [5:0] P1_1 = 6'h01;
  localparam logic [5:0] P1_5 = 6'h05;
  localparam logic [5:0] P1_6 = 6'h06;
  localparam logic [5:0] P1_7 = 6'h07;
  localparam logic [5:0] P2_2 = 6'h0a;
  localparam logic [5:0] P2_4 = 6'h0c;
  localparam logic [5:0] P3_0 = 6'h10;
  localparam logic [5:0] P3_1 = 6'h11;
  localparam logic [5:0] P3_3 = 6'h13;
  localparam logic [5:0] P3_4 = 6'h14;
  localparam logic [5:0] P3_5 = 6'h15;
  localparam logic [5:0] P4_4 = 6'h1c;
  localparam logic [5:0] P4_5 = 6'h1d;
  localparam logic [5:0] P4_7 = 6'h1f;
  localparam logic [5:0] P6_0 = 6'h20;
  localparam logic [5:0] P6_1 = 6'h21;

  localparam logic [5:0] IRQ1_MAP [0:7] = '{P3_3, P3_1, P3_5, P1_0, P6_1, P3_4, P1_5, P2_4};
  localparam logic [5:0] IRQ0_MAP [0:7] = '{P4_5, P3_0, P3_4, P4_7, P6_0, P1_1, P1_7, P2_2};
  localparam logic [5:0] IRQ2_MAP [0:3] = '{P4_4, P3_0, P1_1, P1_6};

endpackage : eirf_pkg

// ==== logic/eirf_route.sv ====
// Pin selection for the three external interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module eirf_route (
  // Synchronised pins
  input  wire logic [39:0] pins,
  // Selectors
  input  wire logic [2:0]  irq0_pin_select,
  input  wire logic [2:0]  irq1_pin_select,
  input  wire logic [1:0]  irq2_pin_select,
  // Routed active-low requests
  output logic      [2:0]  routed_n
);
  assign routed_n[0] = pins[eirf_pkg::IRQ0_MAP[irq0_pin_select]];
  assign routed_n[1] = pins[eirf_pkg::IRQ1_MAP[irq1_pin_select]];
  assign routed_n[2] = pins[eirf_pkg::IRQ2_MAP[irq2_pin_select]];
endmodule : eirf_route
`default_nettype wire

// ==== logic/eirf_filter.sv ====
// Three-sample glitch filter for one external interrupt input
`timescale 1ns/1ps
`default_nettype none
module eirf_filter (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // Mode and sample ticks
  input  wire logic [1:0] mode,
  input  wire logic       tick_div6,
  input  wire logic       tick_serial0,
  // Request in and out, active low
  input  wire logic       pin_n,
  output logic            filt_n
);
  logic [1:0] hist_ff;
  logic       filt_ff;

  wire sample_w = (mode == eirf_pkg::FLT_SYSTEM_CLOCK) ? 1'b1 :
                  (mode == eirf_pkg::FLT_DIV6)   ? tick_div6 : tick_serial0;
  wire agree_w  = (hist_ff[0] == pin_n) && (hist_ff[1] == pin_n);
  wire off_w    = (mode == eirf_pkg::FLT_OFF);
  wire [1:0] nxt_hist = {hist_ff[0], pin_n};

  // History runs every cycle while off so a mode switch starts clean
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hist_ff <= 2'h3;
      filt_ff <= 1'b1;
    end else if (ce && (off_w || sample_w)) begin
      hist_ff <= nxt_hist;
      filt_ff <= (off_w || agree_w) ? pin_n : filt_ff;
    end
  end

  assign filt_n = filt_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  filt_bypass_a: assert property (ce && off_w |=> filt_n == $past(pin_n))
    else $error("unfiltered input not passed in one cycle");
  three_agree_a: assert property (
    $changed(filt_n) && $past(ce, 1) && $past(ce, 2) && $past(ce, 3) &&
    $past(mode, 1) == eirf_pkg::FLT_SYSTEM_CLOCK && $past(mode, 2) == eirf_pkg::FLT_SYSTEM_CLOCK &&
    $past(mode, 3) == eirf_pkg::FLT_SYSTEM_CLOCK
    |-> $past(pin_n, 1) == filt_n && $past(pin_n, 2) == filt_n && $past(pin_n, 3) == filt_n)
    else $error("filtered level changed without three agreeing samples");
  hold_nosample_a: assert property (
    !off_w && !sample_w |=> $stable(filt_n))
    else $error("filtered level moved without a sample tick");
  filt_cov_c: cover property (mode == eirf_pkg::FLT_DIV6 && $fell(filt_n));
endmodule : eirf_filter
`default_nettype wire

// ==== logic/eirf_top.sv ====
// External interrupt routing, input filters and system event flags
`timescale 1ns/1ps
`default_nettype none
module eirf_top (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // Register access
  input  wire logic [7:0] sfr_addr,
  input  wire logic [3:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Port pins, asynchronous
  input  wire logic [7:0] port1_pins,
  input  wire logic [7:0] port2_pins,
  input  wire logic [7:0] port3_pins,
  input  wire logic [7:0] port4_pins,
  input  wire logic [7:0] port6_pins,
  // Hardware events, one-cycle pulses on mclk; the group interrupt enable is a level
  input  wire logic       soft_reset_evt,
  input  wire logic       pin_reset_evt,
  input  wire logic       rtc_ovf_evt,
  input  wire logic       brownout1_evt,
  input  wire logic       brownout0_evt,
  input  wire logic       wdog_ovf_evt,
  input  wire logic       bus_start_evt,
  input  wire logic       bus_stop_evt,
  input  wire logic       serial0_timer_tick,
  input  wire logic       sysflag_group_irq_en,
  // Interrupt outputs
  output logic      [2:0] ext_irq_filt_n,
  output logic            sysflag_req,
  output logic            sysflag_irq,
  // Timer options
  output logic            timer0_tick,
  output logic            timer1_tick,
  output logic            timer0_clkout_en,
  output logic            timer1_clkout_en
);

  // Registers
  logic [7:0] sflag_en_ff;
  logic [7:0] pwr_flags_ff;
  logic [7:0] aux_ff;
  logic [7:0] xcfg_lo_ff;
  logic [7:0] xcfg_hi_ff;
  logic [7:0] rdata_ff;
  logic [39:0] pins_s1_ff;
  logic [39:0] pins_s2_ff;
  logic [2:0] div6_ff;
  logic [3:0] presc_ff;
  logic [1:0] tick_ff;
  logic       req_ff;
  logic       irq_ff;

  // Address decode
  wire hit_en   = (sfr_addr == eirf_pkg::ADDR_SFLAG_EN);
  wire hit_pwr  = (sfr_addr == eirf_pkg::ADDR_PWR_FLAGS);
  wire hit_aux  = (sfr_addr == eirf_pkg::ADDR_AUX_FLAGS) && (sfr_page == eirf_pkg::PAGE_AUX);
  wire hit_xlo  = (sfr_addr == eirf_pkg::ADDR_XCFG) && (sfr_page == eirf_pkg::PAGE_XCFG_LO);
  wire hit_xhi  = (sfr_addr == eirf_pkg::ADDR_XCFG) && (sfr_page == eirf_pkg::PAGE_XCFG_HI);
  wire wr_en    = sfr_wr && hit_en;
  wire wr_pwr   = sfr_wr && hit_pwr;
  wire wr_aux   = sfr_wr && hit_aux;
  wire wr_xlo   = sfr_wr && hit_xlo;
  wire wr_xhi   = sfr_wr && hit_xhi;

  // Reserved bits are dropped, so a careless write cannot land there
  wire [7:0] wdata_en  = sfr_wdata & eirf_pkg::MASK_SFLAG_EN;
  wire [7:0] wdata_x   = sfr_wdata & eirf_pkg::MASK_XCFG;

  // Power event flags: set wins over write-one clear
  wire [7:0] pwr_set = {soft_reset_evt, pin_reset_evt, 1'b0, rtc_ovf_evt, 1'b0,
                        brownout1_evt, brownout0_evt, wdog_ovf_evt};
  wire [7:0] pwr_clr = wr_pwr ? (sfr_wdata & eirf_pkg::MASK_PWR_FLAGS) : 8'h00;
  wire [7:0] nxt_pwr_flags = (pwr_flags_ff & ~pwr_clr) | pwr_set;

  // Bus detect flags clear on written zero, timer options are plain
  wire [1:0] aux_set = {bus_start_evt, bus_stop_evt};
  wire [1:0] aux_clr = wr_aux ? ~sfr_wdata[7:6] : 2'h0;
  wire [1:0] nxt_aux_flags = (aux_ff[7:6] & ~aux_clr) | aux_set;
  wire [3:0] nxt_aux_opts  = wr_aux ? sfr_wdata[3:0] : aux_ff[3:0];
  wire [7:0] nxt_aux = {nxt_aux_flags, 2'h0, nxt_aux_opts};

  // Shared system flag request
  wire bus_detect_flag = aux_ff[eirf_pkg::BIT_BUS_START] | aux_ff[eirf_pkg::BIT_BUS_STOP];
  wire src_bus  = bus_detect_flag & sflag_en_ff[eirf_pkg::BIT_BUS_DET_IE];
  wire src_rtc  = pwr_flags_ff[eirf_pkg::BIT_RTC_OVF] & sflag_en_ff[eirf_pkg::BIT_RTC_IE];
  wire src_bo1  = pwr_flags_ff[eirf_pkg::BIT_BO1] & sflag_en_ff[eirf_pkg::BIT_BO1_IE];
  wire src_bo0  = pwr_flags_ff[eirf_pkg::BIT_BO0] & sflag_en_ff[eirf_pkg::BIT_BO0_IE];
  wire src_wd   = pwr_flags_ff[eirf_pkg::BIT_WDOG_OVF] & sflag_en_ff[eirf_pkg::BIT_WDOG_IE];
  wire nxt_req  = src_bus | src_rtc | src_bo1 | src_bo0 | src_wd;
  wire nxt_irq  = nxt_req & sysflag_group_irq_en;

  // Read mux; unmapped addresses read zero
  wire [7:0] nxt_rdata = hit_en  ? sflag_en_ff :
                         hit_pwr ? pwr_flags_ff :
                         hit_aux ? aux_ff :
                         hit_xlo ? xcfg_lo_ff :
                         hit_xhi ? xcfg_hi_ff : 8'h00;

  // Pin selection and filter modes
  wire [2:0] irq1_pin_select = {xcfg_hi_ff[eirf_pkg::BIT_IRQ1_SEL_HI],
                                xcfg_lo_ff[eirf_pkg::BIT_IRQ1_SEL_LO +: 2]};
  wire [2:0] irq0_pin_select = {xcfg_hi_ff[eirf_pkg::BIT_IRQ0_SEL_HI],
                                xcfg_lo_ff[eirf_pkg::BIT_IRQ0_SEL_LO +: 2]};
  wire [1:0] irq2_pin_select = xcfg_hi_ff[eirf_pkg::BIT_IRQ2_SEL +: 2];
  wire [2:0] routed_n;
  wire       tick_div6 = (div6_ff == eirf_pkg::DIV6_MAX);
  wire       presc_end = (presc_ff == eirf_pkg::PRESC_MAX);
  wire [2:0] nxt_div6  = tick_div6 ? 3'h0 : div6_ff + 3'h1;
  wire [3:0] nxt_presc = presc_end ? 4'h0 : presc_ff + 4'h1;
  wire [39:0] pins_raw = {port6_pins, port4_pins, port3_pins, port2_pins, port1_pins};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sflag_en_ff <= eirf_pkg::RST_SFLAG_EN;
      xcfg_lo_ff  <= eirf_pkg::RST_XCFG;
      xcfg_hi_ff  <= eirf_pkg::RST_XCFG;
      rdata_ff    <= eirf_pkg::RST_RDATA;
    end else if (ce) begin
      sflag_en_ff <= wr_en ? wdata_en : sflag_en_ff;
      xcfg_lo_ff  <= wr_xlo ? wdata_x : xcfg_lo_ff;
      xcfg_hi_ff  <= wr_xhi ? wdata_x : xcfg_hi_ff;
      rdata_ff    <= nxt_rdata;
    end
  end

  // Reset indicators must record the reset that is under way
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_flags_ff <= eirf_pkg::RST_PWR_FLAGS | (pwr_set & eirf_pkg::MASK_RST_KEEP);
      aux_ff       <= eirf_pkg::RST_AUX_FLAGS;
    end else if (ce) begin
      pwr_flags_ff <= nxt_pwr_flags;
      aux_ff       <= nxt_aux;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_ff   <= 1'b0;
      irq_ff   <= 1'b0;
      div6_ff  <= 3'h0;
      presc_ff <= 4'h0;
    end else if (ce) begin
      req_ff   <= nxt_req;
      irq_ff   <= nxt_irq;
      div6_ff  <= nxt_div6;
      presc_ff <= nxt_presc;
    end
  end

  // Two-stage pin synchroniser; only the second stage feeds logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pins_s1_ff <= {eirf_pkg::PIN_W{1'b1}};
      pins_s2_ff <= {eirf_pkg::PIN_W{1'b1}};
    end else if (ce) begin
      pins_s1_ff <= pins_raw;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  eirf_route u_route (
    .pins            (pins_s2_ff),
    .irq0_pin_select (irq0_pin_select),
    .irq1_pin_select (irq1_pin_select),
    .irq2_pin_select (irq2_pin_select),
    .routed_n        (routed_n)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      eirf_filter u_filt (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .ce           (ce),
        .mode         ({xcfg_hi_ff[gi], xcfg_lo_ff[gi]}),
        .tick_div6    (tick_div6),
        .tick_serial0 (serial0_timer_tick),
        .pin_n        (routed_n[gi]),
        .filt_n       (ext_irq_filt_n[gi])
      );
    end
    // Timer ticks: every clock at full rate, else once per twelve
    for (gi = 0; gi < 2; gi++) begin : g_tick
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          tick_ff[gi] <= 1'b0;
        end else if (ce) begin
          tick_ff[gi] <= aux_ff[eirf_pkg::BIT_T0_FULL + gi] | presc_end;
        end
      end
    end
  endgenerate

  assign sfr_rdata        = rdata_ff;
  assign sysflag_req      = req_ff;
  assign sysflag_irq      = irq_ff;
  assign timer0_tick      = tick_ff[0];
  assign timer1_tick      = tick_ff[1];
  assign timer0_clkout_en = aux_ff[eirf_pkg::BIT_T0_CLKOUT];
  assign timer1_clkout_en = aux_ff[eirf_pkg::BIT_T1_CLKOUT];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  route_irq1_a: assert property (irq1_pin_select == 3'h7 |-> routed_n[1] == pins_s2_ff[eirf_pkg::P2_4])
    else $error("irq1 code 7 not routed to its pin");
  route_irq0_a: assert property (irq0_pin_select == 3'h0 |-> routed_n[0] == pins_s2_ff[eirf_pkg::P4_5])
    else $error("irq0 code 0 not routed to its pin");
  route_irq2_a: assert property (irq2_pin_select == 2'h3 |-> routed_n[2] == pins_s2_ff[eirf_pkg::P1_6])
    else $error("irq2 code 3 not routed to its pin");
  soft_set_a: assert property (ce && soft_reset_evt |=> sfr_rdata_soft_dummy())
    else $error("soft reset flag not set after event");
  function automatic logic sfr_rdata_soft_dummy();
    return pwr_flags_ff[eirf_pkg::BIT_SOFT_RST];
  endfunction : sfr_rdata_soft_dummy
  rtc_w0_keep_a: assert property (
    ce && pwr_flags_ff[eirf_pkg::BIT_RTC_OVF] && wr_pwr && !sfr_wdata[eirf_pkg::BIT_RTC_OVF]
    |=> pwr_flags_ff[eirf_pkg::BIT_RTC_OVF])
    else $error("rtc flag lost on a written zero");
  wd_w1c_a: assert property (
    ce && wr_pwr && sfr_wdata[eirf_pkg::BIT_WDOG_OVF] && !wdog_ovf_evt
    |=> !pwr_flags_ff[eirf_pkg::BIT_WDOG_OVF])
    else $error("watchdog flag not cleared by written one");
  start_clr_a: assert property (
    ce && wr_aux && !sfr_wdata[eirf_pkg::BIT_BUS_START] && !bus_start_evt
    |=> !aux_ff[eirf_pkg::BIT_BUS_START])
    else $error("start flag not cleared by written zero");
  stop_w1_keep_a: assert property (
    ce && wr_aux && sfr_wdata[eirf_pkg::BIT_BUS_STOP] && !aux_ff[eirf_pkg::BIT_BUS_STOP] &&
    !bus_stop_evt |=> !aux_ff[eirf_pkg::BIT_BUS_STOP])
    else $error("stop flag set by software write");
  bus_gate_a: assert property (
    ce && !sflag_en_ff[eirf_pkg::BIT_BUS_DET_IE] && !src_rtc && !src_bo1 && !src_bo0 && !src_wd
    |=> !sysflag_req)
    else $error("bus flags raised request while disabled");
  req_or_a: assert property (ce |=> sysflag_req == $past(src_bus | src_rtc | src_bo1 | src_bo0 | src_wd))
    else $error("shared request differs from enabled flags");
  group_gate_a: assert property (ce && !sysflag_group_irq_en |=> !sysflag_irq)
    else $error("shared interrupt passed with group disabled");
  full_rate_a: assert property (ce && aux_ff[eirf_pkg::BIT_T0_FULL] |=> timer0_tick)
    else $error("full-rate timer 0 missed a tick");

  rtc_irq_c: cover property (rtc_ovf_evt ##[1:3] sysflag_irq);
  bus_start_c: cover property (bus_start_evt ##1 wr_aux ##1 !aux_ff[eirf_pkg::BIT_BUS_START]);
  set_clr_c: cover property (wr_pwr && sfr_wdata[eirf_pkg::BIT_WDOG_OVF] && wdog_ovf_evt);
endmodule : eirf_top
`default_nettype wire

// ==== dv/eirf_pin_src.sv ====
// Model of the interrupt sources that pull the port pins low
`timescale 1ns/1ps
`default_nettype none
module eirf_pin_src (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Level requests from the bench
  input  wire logic       set_en,
  input  wire logic [5:0] set_idx,
  input  wire logic       set_lvl,
  // Port pins, idle high like pulled-up request lines
  output logic      [7:0] port1_pins,
  output logic      [7:0] port2_pins,
  output logic      [7:0] port3_pins,
  output logic      [7:0] port4_pins,
  output logic      [7:0] port6_pins
);
  logic [39:0] pins_ff;

  // Changes land just after an edge, never in step with the sampler
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pins_ff <= '1;
    end else if (set_en) begin
      pins_ff[set_idx] <= set_lvl;
    end
  end

  assign port1_pins = pins_ff[7:0];
  assign port2_pins = pins_ff[15:8];
  assign port3_pins = pins_ff[23:16];
  assign port4_pins = pins_ff[31:24];
  assign port6_pins = pins_ff[39:32];
endmodule : eirf_pin_src
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for interrupt routing, filters and system flags
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk;
  logic        sys_rst;
  logic [7:0]  sfr_addr;
  logic [3:0]  sfr_page;
  logic        sfr_wr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  wire  [39:0] pins;
  logic [7:0]  evt;
  logic        s0_tick;
  logic        grp_en;
  logic [2:0]  filt_n;
  logic        req;
  logic        irq;
  logic [1:0]  tick;
  logic [1:0]  clkout;
  logic        set_en;
  logic [5:0]  set_idx;
  logic        set_lvl;
  logic [7:0]  d;
  logic [7:0]  en;
  logic [7:0]  a;
  logic        ex;
  logic        lo;
  int          n0;
  int          n1;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Pin number per select code; port1 at 0, port2 8, port3 16, port4 24, port6 32
  localparam int M0 [8] = '{29, 16, 20, 31, 32, 1, 7, 10};
  localparam int M1 [8] = '{19, 17, 21, 0, 33, 20, 5, 12};
  localparam int M2 [4] = '{28, 16, 1, 6};
  // Flag bit per event: soft, pin, rtc, bo1, bo0, wdog, start, stop
  localparam int FB [8] = '{7, 6, 4, 2, 1, 0, 7, 6};

  eirf_pin_src i_src (.mclk(mclk), .sys_rst(sys_rst), .set_en(set_en), .set_idx(set_idx),
    .set_lvl(set_lvl), .port1_pins(pins[7:0]), .port2_pins(pins[15:8]),
    .port3_pins(pins[23:16]), .port4_pins(pins[31:24]), .port6_pins(pins[39:32]));

  eirf_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .port1_pins(pins[7:0]), .port2_pins(pins[15:8]), .port3_pins(pins[23:16]),
    .port4_pins(pins[31:24]), .port6_pins(pins[39:32]), .soft_reset_evt(evt[0]),
    .pin_reset_evt(evt[1]), .rtc_ovf_evt(evt[2]), .brownout1_evt(evt[3]),
    .brownout0_evt(evt[4]), .wdog_ovf_evt(evt[5]), .bus_start_evt(evt[6]),
    .bus_stop_evt(evt[7]), .serial0_timer_tick(s0_tick), .sysflag_group_irq_en(grp_en),
    .ext_irq_filt_n(filt_n), .sysflag_req(req), .sysflag_irq(irq), .timer0_tick(tick[0]),
    .timer1_tick(tick[1]), .timer0_clkout_en(clkout[0]), .timer1_clkout_en(clkout[1]));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc_n

  task automatic wr(input logic [7:0] ad, input logic [3:0] pg, input logic [7:0] v);
    sfr_addr = ad;
    sfr_page = pg;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    cyc_n(1);
  endtask : wr

  // Read data is registered, so it is taken one cycle after the address
  task automatic rc(input string nm, input logic [7:0] ad, input logic [3:0] pg,
                    input logic [7:0] exp);
    sfr_wr = 1'b0;
    sfr_addr = ad;
    sfr_page = pg;
    cyc_n(1);
    chk(nm, sfr_rdata, exp);
  endtask : rc

  task automatic pin(input int idx, input logic lvl);
    set_idx = 6'(idx);
    set_lvl = lvl;
    set_en = 1'b1;
    cyc_n(1);
  endtask : pin

  task automatic cfg(input logic [2:0] c0, input logic [2:0] c1, input logic [1:0] c2,
                     input logic [1:0] m);
    wr(eirf_pkg::ADDR_XCFG, 4'h0, {c1[1:0], c0[1:0], 1'b0, {3{m[0]}}});
    wr(eirf_pkg::ADDR_XCFG, 4'h1, {c1[2], c0[2], c2, 1'b0, {3{m[1]}}});
  endtask : cfg

  // Any glitch on irq0 must be caught, so every cycle is looked at
  task automatic low_seen(input int n);
    lo = 1'b0;
    repeat (n) begin
      cyc_n(1);
      if (filt_n[0] !== 1'b1) lo = 1'b1;
    end
  endtask : low_seen

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      $display("timeout after %0d cycles", cyc);
      results();
    end
  end

  initial begin
    {sys_rst, sfr_addr, sfr_page, sfr_wr, sfr_wdata} = {1'b1, 21'h0};
    {evt, s0_tick, grp_en, set_en, set_idx, set_lvl} = {17'h0, 1'b1};
    void'($urandom(32'h6029));
    cyc_n(16);
    sys_rst = 1'b0;
    rc("en reset", eirf_pkg::ADDR_SFLAG_EN, 4'h0, 8'h00);
    rc("pwr reset", eirf_pkg::ADDR_PWR_FLAGS, 4'h0, 8'h00);
    rc("aux reset", eirf_pkg::ADDR_AUX_FLAGS, 4'h0, 8'h00);
    rc("cfg lo reset", eirf_pkg::ADDR_XCFG, 4'h0, 8'h00);
    rc("cfg hi reset", eirf_pkg::ADDR_XCFG, 4'h1, 8'h00);
    $display("test reset done");
    repeat (4) begin
      d = 8'($urandom);
      wr(eirf_pkg::ADDR_SFLAG_EN, 4'h0, d & 8'h97);
      rc("en rw", eirf_pkg::ADDR_SFLAG_EN, 4'h0, d & 8'h97);
      cfg(d[5:3], d[2:0], d[7:6], d[1:0]);
      rc("cfg lo", eirf_pkg::ADDR_XCFG, 4'h0, {d[1:0], d[4:3], 1'b0, {3{d[0]}}});
      rc("cfg hi", eirf_pkg::ADDR_XCFG, 4'h1, {d[2], d[5], d[7:6], 1'b0, {3{d[1]}}});
      wr(8'h90, 4'h0, d);
      rc("unmapped", 8'h90, 4'h0, 8'h00);
      wr(eirf_pkg::ADDR_AUX_FLAGS, 4'h0, d & 8'h0f);
      cyc_n(2);
      chk("clkout", {6'h0, clkout}, {6'h0, d[1:0]});
      {n0, n1} = 0;
      repeat (24) begin
        cyc_n(1);
        if (tick[0] === 1'b1) n0++;
        if (tick[1] === 1'b1) n1++;
      end
      chk("timer0 ticks", 8'(n0), d[2] ? 8'h18 : 8'h02);
      chk("timer1 ticks", 8'(n1), d[3] ? 8'h18 : 8'h02);
    end
    wr(eirf_pkg::ADDR_AUX_FLAGS, 4'h0, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      en = 8'($urandom) & 8'h97;
      grp_en = 1'($urandom);
      wr(eirf_pkg::ADDR_SFLAG_EN, 4'h0, en);
      evt[i % 8] = 1'b1;
      cyc_n(1);
      evt = 8'h00;
      cyc_n(2);
      ex = (i % 8 < 2) ? 1'b0 : en[(i % 8 < 6) ? FB[i % 8] : 7];
      chk("req", {7'h0, req}, {7'h0, ex});
      chk("irq", {7'h0, irq}, {7'h0, ex & grp_en});
      a = (i % 8 < 6) ? eirf_pkg::ADDR_PWR_FLAGS : eirf_pkg::ADDR_AUX_FLAGS;
      rc("flag set", a, 4'h0, 8'h01 << FB[i % 8]);
      wr(a, 4'h0, (i % 8 < 6) ? 8'h00 : 8'hc0);
      rc("flag kept", a, 4'h0, 8'h01 << FB[i % 8]);
      wr(a, 4'h0, (i % 8 < 6) ? (8'h01 << FB[i % 8]) : 8'h00);
      rc("flag cleared", a, 4'h0, 8'h00);
      cyc_n(1);
      chk("req cleared", {7'h0, req}, 8'h00);
    end
    evt[2] = 1'b1;
    wr(eirf_pkg::ADDR_PWR_FLAGS, 4'h0, 8'h10);
    evt[2] = 1'b0;
    rc("set beats clear", eirf_pkg::ADDR_PWR_FLAGS, 4'h0, 8'h10);
    sys_rst = 1'b1;
    cyc_n(2);
    evt[1:0] = 2'b11;
    cyc_n(1);
    evt[1:0] = 2'b00;
    sys_rst = 1'b0;
    rc("reset causes", eirf_pkg::ADDR_PWR_FLAGS, 4'h0, 8'hc0);
    wr(eirf_pkg::ADDR_PWR_FLAGS, 4'h0, 8'hc0);
    wr(eirf_pkg::ADDR_AUX_FLAGS, 4'h0, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < ((k == 2) ? 4 : 8); c++) begin
        cfg(3'(c), 3'(c), 2'(c), eirf_pkg::FLT_OFF);
        pin((k == 0) ? M0[c ^ 1] : (k == 1) ? M1[c ^ 1] : M2[c ^ 1], 1'b0);
        cyc_n(4);
        chk("other pin", {7'h0, filt_n[k]}, 8'h01);
        pin((k == 0) ? M0[c] : (k == 1) ? M1[c] : M2[c], 1'b0);
        cyc_n(4);
        chk("routed pin", {7'h0, filt_n[k]}, 8'h00);
        pin((k == 0) ? M0[c] : (k == 1) ? M1[c] : M2[c], 1'b1);
        pin((k == 0) ? M0[c ^ 1] : (k == 1) ? M1[c ^ 1] : M2[c ^ 1], 1'b1);
        cyc_n(4);
      end
    end
    $display("test routing done");
    cfg(3'h0, 3'h0, 2'h0, eirf_pkg::FLT_SYSTEM_CLOCK);
    pin(29, 1'b0);
    cyc_n(1);
    pin(29, 1'b1);
    low_seen(10);
    chk("short glitch", {7'h0, lo}, 8'h00);
    pin(29, 1'b0);
    low_seen(4);
    chk("early step", {7'h0, lo}, 8'h00);
    cyc_n(4);
    chk("step", {7'h0, filt_n[0]}, 8'h00);
    pin(29, 1'b1);
    cyc_n(10);
    cfg(3'h0, 3'h0, 2'h0, eirf_pkg::FLT_OFF);
    pin(29, 1'b0);
    cyc_n(1);
    pin(29, 1'b1);
    low_seen(10);
    chk("unfiltered glitch", {7'h0, lo}, 8'h01);
    cfg(3'h0, 3'h0, 2'h0, eirf_pkg::FLT_DIV6);
    pin(29, 1'b0);
    cyc_n(10);
    pin(29, 1'b1);
    low_seen(20);
    chk("slow glitch", {7'h0, lo}, 8'h00);
    pin(29, 1'b0);
    cyc_n(30);
    chk("slow step", {7'h0, filt_n[0]}, 8'h00);
    pin(29, 1'b1);
    cyc_n(30);
    cfg(3'h0, 3'h0, 2'h0, eirf_pkg::FLT_SERIAL0);
    pin(29, 1'b0);
    low_seen(30);
    chk("no serial tick", {7'h0, lo}, 8'h00);
    for (int t = 0; t < 3; t++) begin
      s0_tick = 1'b1;
      cyc_n(1);
      s0_tick = 1'b0;
      cyc_n(2);
      chk("serial sample", {7'h0, filt_n[0]}, (t == 2) ? 8'h00 : 8'h01);
    end
    pin(29, 1'b1);
    $display("test filters done");
    results();
  end
endmodule : tb_top
`default_nettype wire
